// ==== common/bvs_pkg.sv ====
package bvs_pkg;
    // Numeric formats carried over the fieldbus
    typedef enum logic [3:0] {
        BVS_INT8, BVS_INT16, BVS_INT32,
        BVS_UINT8, BVS_UINT16, BVS_UINT32,
        BVS_FIXED16_SIX_FRAC, BVS_FIXED32_MILLI,
        BVS_SCALED_INT16, BVS_SCALED_INT32,
        BVS_BIT_SEQUENCE_16, BVS_OCTET_STRING
    } bvs_fmt_t;

    // Register indices (address = index), short scale group first
    localparam logic [4:0] IDX_Y2_SPEED            = 5'h00;
    localparam logic [4:0] IDX_Y2_POSITION         = 5'h01;
    localparam logic [4:0] IDX_Y2_VOLTAGE          = 5'h02;
    localparam logic [4:0] IDX_Y2_CURRENT          = 5'h0a;
    localparam logic [4:0] IDX_Y4_BASE             = 5'h0b;
    localparam logic [4:0] IDX_Y4_SPEED            = 5'h0b;
    localparam logic [4:0] IDX_Y4_POSITION         = 5'h0c;
    localparam logic [4:0] IDX_Y4_VOLTAGE          = 5'h0d;
    localparam logic [4:0] IDX_Y4_INTERPOLATION    = 5'h13;
    localparam logic [4:0] IDX_Y4_TARGET_VELOCITY  = 5'h14;
    localparam logic [4:0] IDX_Y4_ACCEL_INPUT      = 5'h17;
    localparam logic [4:0] IDX_STATUS              = 5'h18;
    localparam int         NUM_SCALE               = 24;
    localparam logic [3:0] NUM_SHORT               = 4'hb;
    localparam logic [3:0] NUM_LONG                = 4'hd;

    // Factor word fields
    localparam int         FAMILY_BIT              = 5;
    localparam logic [4:0] DEC_EXP_MAX             = 5'h09;
    localparam logic [4:0] BIN_EXP_MAX             = 5'h18;
    localparam logic [15:0] SCALE_RESET            = 16'h0000;

    // Fixed formats: six binary places, three decimal places
    localparam logic [4:0] FIXED16_FRAC_BITS       = 5'h06;
    localparam logic [4:0] MILLI_DEC_EXP           = 5'h03;

    // Status register bits
    localparam int         ST_BUSY                 = 0;
    localparam int         ST_ERR                  = 1;
    localparam int         ST_SAT                  = 2;
endpackage

// ==== rtl/bvs_scaler.sv ====
`timescale 1ns/1ns
module bvs_scaler
    import bvs_pkg::*;
#(
    parameter int FRAC  = 16,                      // Fraction bits of the internal value
    parameter int INT_W = 48                       // Width of the internal value
) (
    input  wire logic               mclk_in,       // Core clock, 20 MHz
    input  wire logic               rst_in,        // Synchronous reset, active high
    input  wire logic               ce_in,         // Clock enable, freezes all state when low; reset still acts
    input  wire logic [4:0]         reg_addr_in,   // Register index
    input  wire logic [15:0]        reg_wdata_in,  // Register write data
    input  wire logic               reg_wr_in,     // Write strobe
    input  wire logic               reg_rd_in,     // Read strobe
    output logic      [15:0]        reg_rdata_out, // Read data, cycle after strobe
    input  wire logic               conv_start_in, // Conversion request
    input  wire logic               conv_dir_in,   // 0: bus to internal, 1: internal to bus
    input  wire logic [3:0]         conv_fmt_in,   // Format, bvs_fmt_t
    input  wire logic [3:0]         conv_idx_in,   // Quantity index within scale group
    input  wire logic [2:0]         conv_len_in,   // Octet count for octet strings, 1..4
    input  wire logic [INT_W-1:0]   conv_data_in,  // Raw word in [31:0] or internal value
    output logic                    conv_ready_out,// Ready for a request
    output logic                    res_valid_out, // Result pulse
    output logic      [INT_W-1:0]   res_data_out,  // Result word
    output logic                    res_sat_out,   // Result was clamped
    output logic                    res_err_out    // Request refused
);
    // Elaboration check on the datapath geometry
    if (FRAC < 6 || FRAC > 24 || INT_W < 32 + FRAC || INT_W > 64) begin : g_bad_param
        $error("bvs_scaler: unsupported FRAC or INT_W");
    end

    typedef enum {ST_IDLE, ST_STEP} bvs_state_t;

    localparam int ACC_W = 96;                     // Wide enough for 48 bits times ten to the nine

    // Saturation test against a signed or unsigned width
    function automatic logic bvs_over(input logic signed [ACC_W-1:0] v, input int w, input logic uns);
        logic signed [ACC_W-1:0] hi;
        logic signed [ACC_W-1:0] lo;
        hi = uns ? (96'sh1 <<< w) - 96'sh1 : (96'sh1 <<< (w - 1)) - 96'sh1;
        lo = uns ? 96'sh0 : -(96'sh1 <<< (w - 1));
        return (v > hi) || (v < lo);
    endfunction

    // Clamp to the nearest representable value
    function automatic logic [63:0] bvs_clamp(input logic signed [ACC_W-1:0] v, input int w, input logic uns);
        logic signed [ACC_W-1:0] hi;
        logic signed [ACC_W-1:0] lo;
        logic signed [ACC_W-1:0] r;
        hi = uns ? (96'sh1 <<< w) - 96'sh1 : (96'sh1 <<< (w - 1)) - 96'sh1;
        lo = uns ? 96'sh0 : -(96'sh1 <<< (w - 1));
        r  = (v > hi) ? hi : ((v < lo) ? lo : v);
        return r[63:0];
    endfunction

    // Scale factor storage and status
    logic [15:0]                scale_q [NUM_SCALE];  // Factor words, full width kept
    logic                       err_st_q;             // Sticky refused-request flag
    logic                       sat_st_q;             // Sticky saturation flag
    logic [15:0]                rdata_q;              // Registered read data

    // Conversion state
    bvs_state_t                 state_q;
    logic signed [ACC_W-1:0]    acc_q;                // Working accumulator
    logic [4:0]                 cnt_q;                // Remaining decimal steps
    logic                       dir_q;
    bvs_fmt_t                   fmt_q;
    logic                       valid_q;
    logic [INT_W-1:0]           res_q;
    logic                       rsat_q;
    logic                       rerr_q;

    // Request decode
    bvs_fmt_t                   fmt_w;
    logic                       take_w;
    logic                       short_w;
    logic                       long_w;
    logic [4:0]                 sel_w;
    logic                       idx_bad_w;
    logic [15:0]                factor_w;
    logic                       family_bin_w;
    logic [4:0]                 exp_w;
    logic                       exp_bad_w;
    logic                       len_bad_w;
    logic                       req_bad_w;
    logic [4:0]                 dec_n_w;
    logic [4:0]                 bin_n_w;
    logic signed [ACC_W-1:0]    raw_ext_w;
    logic signed [ACC_W-1:0]    int_ext_w;
    logic signed [ACC_W-1:0]    load_w;
    logic [31:0]                octet_mask_w;
    logic                       passthru_w;

    assign fmt_w   = bvs_fmt_t'(conv_fmt_in);
    assign take_w  = ce_in && conv_start_in && (state_q == ST_IDLE);
    assign short_w = (fmt_w == BVS_SCALED_INT16);
    assign long_w  = (fmt_w == BVS_SCALED_INT32);

    // Short scaled values read the short group, long the long group
    // Long index 8 is the interpolation position factor, index 9 the target velocity factor
    assign sel_w     = long_w ? IDX_Y4_BASE + {1'b0, conv_idx_in} : {1'b0, conv_idx_in};
    assign idx_bad_w = (short_w && conv_idx_in >= NUM_SHORT) || (long_w && conv_idx_in >= NUM_LONG);
    assign factor_w  = idx_bad_w ? SCALE_RESET : scale_q[sel_w];

    // Only bits 5..0 of a factor word take part; the upper bits are stored but ignored
    assign family_bin_w = factor_w[FAMILY_BIT];
    assign exp_w        = factor_w[4:0];
    assign exp_bad_w    = (short_w || long_w) &&
                          (family_bin_w ? (exp_w > BIN_EXP_MAX) : (exp_w > DEC_EXP_MAX));
    assign len_bad_w    = (fmt_w == BVS_OCTET_STRING) && (conv_len_in == 3'h0 || conv_len_in > 3'h4);
    assign req_bad_w    = idx_bad_w || exp_bad_w || len_bad_w || (conv_fmt_in > 4'hb);

    // Decimal and binary exponent of the selected operation
    assign dec_n_w = (fmt_w == BVS_FIXED32_MILLI) ? MILLI_DEC_EXP :
                     ((short_w || long_w) && !family_bin_w) ? exp_w : 5'h00;
    assign bin_n_w = (fmt_w == BVS_FIXED16_SIX_FRAC) ? FIXED16_FRAC_BITS :
                     ((short_w || long_w) && family_bin_w) ? exp_w : 5'h00;

    // Raw bus word widened by format: signed forms sign-extend, unsigned zero-extend
    always_comb begin
        raw_ext_w = 96'sh0;
        case (fmt_w)
            BVS_INT8:             raw_ext_w = $signed({{88{conv_data_in[7]}}, conv_data_in[7:0]});
            BVS_INT16,
            BVS_FIXED16_SIX_FRAC,
            BVS_SCALED_INT16:     raw_ext_w = $signed({{80{conv_data_in[15]}}, conv_data_in[15:0]});
            BVS_INT32,
            BVS_FIXED32_MILLI,
            BVS_SCALED_INT32:     raw_ext_w = $signed({{64{conv_data_in[31]}}, conv_data_in[31:0]});
            BVS_UINT8:            raw_ext_w = $signed({88'h0, conv_data_in[7:0]});
            BVS_UINT16:           raw_ext_w = $signed({80'h0, conv_data_in[15:0]});
            BVS_UINT32:           raw_ext_w = $signed({64'h0, conv_data_in[31:0]});
            default:              raw_ext_w = 96'sh0;
        endcase
    end

    // Internal value is a signed fixed-point number with FRAC fraction bits
    assign int_ext_w = $signed({{(ACC_W-INT_W){conv_data_in[INT_W-1]}}, conv_data_in});

    // Octet strings keep the first bytes sent, which sit at the top of the word
    assign octet_mask_w = ~(32'hffffffff >> (8 * conv_len_in));
    assign passthru_w   = (fmt_w == BVS_BIT_SEQUENCE_16) || (fmt_w == BVS_OCTET_STRING);

    // Accumulator start value; binary scaling is one shift done here
    always_comb begin
        load_w = 96'sh0;
        if (fmt_w == BVS_BIT_SEQUENCE_16) begin
            load_w = $signed({80'h0, conv_data_in[15:0]});
        end else if (fmt_w == BVS_OCTET_STRING) begin
            load_w = $signed({64'h0, conv_data_in[31:0] & octet_mask_w});
        end else if (conv_dir_in) begin
            load_w = int_ext_w <<< bin_n_w;
        end else begin
            load_w = (raw_ext_w <<< FRAC) >>> bin_n_w;
        end
    end

    // Result shaping: drop the fraction when encoding, then clamp to the target format
    logic signed [ACC_W-1:0]    fin_w;
    int                         fin_width_w;
    logic                       fin_uns_w;
    logic                       fin_over_w;
    logic [63:0]                fin_clamp_w;
    logic [INT_W-1:0]           fin_data_w;
    logic                       fin_pass_w;

    assign fin_pass_w = (fmt_q == BVS_BIT_SEQUENCE_16) || (fmt_q == BVS_OCTET_STRING);
    assign fin_w      = dir_q ? (acc_q >>> FRAC) : acc_q;

    always_comb begin
        fin_width_w = INT_W;
        fin_uns_w   = 1'b0;
        if (dir_q) begin
            case (fmt_q)
                BVS_INT8:   fin_width_w = 8;
                BVS_UINT8: begin
                    fin_width_w = 8;
                    fin_uns_w   = 1'b1;
                end
                BVS_UINT16: begin
                    fin_width_w = 16;
                    fin_uns_w   = 1'b1;
                end
                BVS_UINT32: begin
                    fin_width_w = 32;
                    fin_uns_w   = 1'b1;
                end
                BVS_INT16,
                BVS_FIXED16_SIX_FRAC,
                BVS_SCALED_INT16: fin_width_w = 16;
                default:          fin_width_w = 32;
            endcase
        end
    end

    assign fin_over_w  = !fin_pass_w && bvs_over(fin_w, fin_width_w, fin_uns_w);
    assign fin_clamp_w = bvs_clamp(fin_w, fin_width_w, fin_uns_w);

    // Encoded raw words are zero-filled above their width so the bus sees exact bytes
    always_comb begin
        fin_data_w = '0;
        if (fin_pass_w) begin
            fin_data_w = acc_q[INT_W-1:0];
        end else if (dir_q) begin
            fin_data_w = INT_W'(fin_clamp_w & ((64'h1 << fin_width_w) - 64'h1));
        end else begin
            fin_data_w = fin_clamp_w[INT_W-1:0];
        end
    end

    // Conversion sequencer: one multiply or divide by ten per cycle keeps the logic small at the cost of latency
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            state_q <= ST_IDLE;
            acc_q   <= 96'sh0;
            cnt_q   <= 5'h00;
            dir_q   <= 1'b0;
            fmt_q   <= BVS_INT8;
            valid_q <= 1'b0;
            res_q   <= '0;
            rsat_q  <= 1'b0;
            rerr_q  <= 1'b0;
        end else if (ce_in) begin
            valid_q <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (take_w && req_bad_w) begin
                        // Refused request answers at once with zero data
                        valid_q <= 1'b1;
                        res_q   <= '0;
                        rsat_q  <= 1'b0;
                        rerr_q  <= 1'b1;
                    end else if (take_w) begin
                        acc_q   <= load_w;
                        cnt_q   <= passthru_w ? 5'h00 : dec_n_w;
                        dir_q   <= conv_dir_in;
                        fmt_q   <= fmt_w;
                        state_q <= ST_STEP;
                    end
                end
                ST_STEP: begin
                    if (cnt_q != 5'h00) begin
                        // Decode divides, encode multiplies, by ten per step
                        acc_q <= dir_q ? acc_q * 96'sha : acc_q / 96'sha;
                        cnt_q <= cnt_q - 5'h01;
                    end else begin
                        valid_q <= 1'b1;
                        res_q   <= fin_data_w;
                        rsat_q  <= fin_over_w;
                        rerr_q  <= 1'b0;
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Register writes and sticky status; a new event beats a clear in the same cycle
    logic                       wr_scale_w;
    logic                       wr_status_w;
    logic                       ev_err_w;
    logic                       ev_sat_w;

    assign wr_scale_w  = reg_wr_in && (reg_addr_in < IDX_STATUS);
    assign wr_status_w = reg_wr_in && (reg_addr_in == IDX_STATUS);
    assign ev_err_w    = take_w && req_bad_w;
    assign ev_sat_w    = (state_q == ST_STEP) && (cnt_q == 5'h00) && fin_over_w;

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            for (int i = 0; i < NUM_SCALE; i++) begin
                scale_q[i] <= SCALE_RESET;
            end
            err_st_q <= 1'b0;
            sat_st_q <= 1'b0;
        end else if (ce_in) begin
            if (wr_scale_w) begin
                scale_q[reg_addr_in] <= reg_wdata_in;
            end
            err_st_q <= ev_err_w || (err_st_q && !(wr_status_w && reg_wdata_in[ST_ERR]));
            sat_st_q <= ev_sat_w || (sat_st_q && !(wr_status_w && reg_wdata_in[ST_SAT]));
        end
    end

    // Read mux; unmapped indices read zero
    logic [15:0]                rd_mux_w;
    assign rd_mux_w = (reg_addr_in < IDX_STATUS) ? scale_q[reg_addr_in] :
                      (reg_addr_in == IDX_STATUS) ?
                      {13'h0, sat_st_q, err_st_q, (state_q == ST_STEP)} : 16'h0000;

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            rdata_q <= 16'h0000;
        end else if (ce_in) begin
            rdata_q <= reg_rd_in ? rd_mux_w : 16'h0000;
        end
    end

    assign reg_rdata_out  = rdata_q;
    assign conv_ready_out = (state_q == ST_IDLE);
    assign res_valid_out  = valid_q;
    assign res_data_out   = res_q;
    assign res_sat_out    = rsat_q;
    assign res_err_out    = rerr_q;
endmodule

// ==== tb/bvs_scaler_props.sv ====
`timescale 1ns/1ns
module bvs_scaler_props
    import bvs_pkg::*;
#(
    parameter int FRAC  = 16,                   // Fraction bits
    parameter int INT_W = 48                    // Internal width
) (
    input  wire logic             mclk_in,      // Core clock
    input  wire logic             rst_in,       // Synchronous reset
    input  wire logic             ce_in,        // Clock enable
    input  wire logic             reg_rd_in,    // Read strobe
    input  wire logic [15:0]      reg_rdata_out,// Read data
    input  wire logic             conv_start_in,// Conversion request
    input  wire logic             conv_dir_in,  // Conversion direction
    input  wire logic [3:0]       conv_fmt_in,  // Format code
    input  wire logic [2:0]       conv_len_in,  // Octet count
    input  wire logic [INT_W-1:0] conv_data_in, // Raw word or internal value
    input  wire logic             conv_ready_out,// Ready for a request
    input  wire logic             res_valid_out,// Result pulse
    input  wire logic [INT_W-1:0] res_data_out, // Result word
    input  wire logic             res_sat_out,  // Result clamped
    input  wire logic             res_err_out   // Request refused
);
    logic [15:0] raw16; // Low half-word for $past
    logic        take;  // Decode taken here
    assign raw16 = conv_data_in[15:0];
    assign take  = conv_start_in && conv_ready_out && ce_in && !conv_dir_in;

    // Core clock, checks disabled in reset
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);

    property p_rdata_idle; ce_in && !reg_rd_in |=> reg_rdata_out == 16'h0000; endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data not zero");
    property p_valid_pulse; res_valid_out && ce_in |=> !res_valid_out; endproperty
    a_valid_pulse: assert property (p_valid_pulse)
        else $error("result pulse too long");
    property p_int16;
        take && conv_fmt_in == BVS_INT16 |=> !conv_ready_out ##1
            (res_valid_out && !res_err_out && res_data_out == (INT_W'($signed($past(raw16, 2))) << FRAC));
    endproperty
    a_int16: assert property (p_int16)
        else $error("signed word decode wrong");
    property p_fixed16;
        take && conv_fmt_in == BVS_FIXED16_SIX_FRAC |-> ##2
            res_valid_out && res_data_out == (INT_W'($signed($past(raw16, 2))) << (FRAC - 6));
    endproperty
    a_fixed16: assert property (p_fixed16)
        else $error("fixed decode wrong");
    property p_milli_lat; take && conv_fmt_in == BVS_FIXED32_MILLI |=> !res_valid_out [*4] ##1 res_valid_out; endproperty
    a_milli_lat: assert property (p_milli_lat)
        else $error("milli decode latency wrong");
    property p_bitseq;
        take && conv_fmt_in == BVS_BIT_SEQUENCE_16 |-> ##2
            res_valid_out && !res_sat_out && res_data_out[15:0] == $past(raw16, 2);
    endproperty
    a_bitseq: assert property (p_bitseq)
        else $error("bit sequence altered");
    property p_octet_len;
        take && conv_fmt_in == BVS_OCTET_STRING && (conv_len_in == 3'h0 || conv_len_in > 3'h4)
            |=> res_valid_out && res_err_out;
    endproperty
    a_octet_len: assert property (p_octet_len)
        else $error("bad octet count not refused");
    property p_err_zero; res_valid_out && res_err_out |-> res_data_out == '0; endproperty
    a_err_zero: assert property (p_err_zero)
        else $error("refused request left data");
    property p_busy_bound; !conv_ready_out |-> ##[1:12] conv_ready_out; endproperty
    a_busy_bound: assert property (p_busy_bound)
        else $error("conversion busy too long");
endmodule

bind bvs_scaler bvs_scaler_props #(.FRAC(FRAC), .INT_W(INT_W)) props_u (
    .mclk_in(mclk_in), .rst_in(rst_in), .ce_in(ce_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .conv_start_in(conv_start_in), .conv_dir_in(conv_dir_in), .conv_fmt_in(conv_fmt_in),
    .conv_len_in(conv_len_in), .conv_data_in(conv_data_in), .conv_ready_out(conv_ready_out),
    .res_valid_out(res_valid_out), .res_data_out(res_data_out), .res_sat_out(res_sat_out),
    .res_err_out(res_err_out));

// ==== tb/bvs_fieldbus_master.sv ====
`timescale 1ns/1ns
module bvs_fieldbus_master
    import bvs_pkg::*;
(
    input  wire logic        mclk_in,   // Core clock
    input  wire logic        ready_in,  // Scaler can take a request
    input  wire logic        valid_in,  // Result pulse
    input  wire logic [47:0] result_in, // Result word
    input  wire logic        sat_in,    // Result clamped
    input  wire logic        err_in,    // Request refused
    output logic             start_out, // Request strobe
    output logic             dir_out,   // 0 decode, 1 encode
    output logic [3:0]       fmt_out,   // Format code
    output logic [3:0]       idx_out,   // Quantity index
    output logic [2:0]       len_out,   // Octet count
    output logic [47:0]      data_out   // Raw word or internal value
);
    // Idle lines
    initial begin
        start_out = 1'b0;
        dir_out   = 1'b0;
        fmt_out   = 4'h0;
        idx_out   = 4'h0;
        len_out   = 3'h0;
        data_out  = 48'h0;
    end

    // One request held until taken; result and edges to it
    task automatic transfer(input logic d, input logic [3:0] f, input logic [3:0] i, input logic [2:0] l,
                            input logic [47:0] w, output logic [47:0] got, output logic s, output logic e,
                            output int lat);
        int n;
        n = 0;
        start_out <= 1'b1;
        dir_out   <= d;
        fmt_out   <= f;
        idx_out   <= i;
        len_out   <= l;
        data_out  <= w;
        @(posedge mclk_in);
        while (ready_in !== 1'b1 && n < 50) begin
            @(posedge mclk_in);
            n++;
        end
        // Released data and format lines show the inverse
        start_out <= 1'b0;
        data_out  <= ~w;
        fmt_out   <= ~f;
        lat = 0;
        while (lat < 20) begin
            @(posedge mclk_in);
            lat++;
            if (valid_in === 1'b1) break;
        end
        got = result_in;
        s   = sat_in;
        e   = err_in;
    endtask
endmodule

// ==== tb/bvs_scaler_tb_top.sv ====
`timescale 1ns/1ns
module bvs_scaler_tb_top import bvs_pkg::*;;
    // Request beside expected result
    typedef struct {
        logic dir; logic [3:0] fmt; logic [3:0] idx; logic [2:0] len;
        logic [47:0] data; logic [47:0] exp; logic sat; logic err; int lat;
    } bvs_row_t;
    logic        mclk_in = 1'b0, rst_in = 1'b1, ce_in = 1'b1;
    logic        reg_wr_in = 1'b0, reg_rd_in = 1'b0;
    logic [4:0]  reg_addr_in = 5'h00;
    logic [15:0] reg_wdata_in = 16'h0000, reg_rdata_out;
    logic        conv_start_in, conv_dir_in, conv_ready_out, res_valid_out, res_sat_out, res_err_out;
    logic [3:0]  conv_fmt_in, conv_idx_in;
    logic [2:0]  conv_len_in;
    logic [47:0] conv_data_in, res_data_out, got;
    logic        s, e;
    int          bad_count = 0, tests_run = 0, cycles = 0, lat;
    // Factor set-up incl. reserved bits and bad exponents
    logic [4:0]  sa [8] = '{5'h00, 5'h01, 5'h02, 5'h0b, 5'h0c, 5'h0d, 5'h13, 5'h14};
    logic [15:0] sv [8] = '{16'h0021, 16'h0001, 16'h0022, 16'hffc2, 16'h000a, 16'h0039, 16'h0022, 16'h0003};
    bvs_row_t rows [23] = '{
        '{0, BVS_INT8, 0, 0, 48'h80, 48'hffff_ff80_0000, 0, 0, 2},
        '{0, BVS_INT32, 0, 0, 48'h8000_0000, 48'h8000_0000_0000, 0, 0, 2},
        '{0, BVS_INT16, 0, 0, 48'h8001, 48'hffff_8001_0000, 0, 0, 2},
        '{0, BVS_UINT8, 0, 0, 48'h80, 48'h80_0000, 0, 0, 2},
        '{0, BVS_UINT32, 0, 0, 48'hffff_ffff, 48'h7fff_ffff_ffff, 1, 0, 2},
        '{0, BVS_FIXED16_SIX_FRAC, 0, 0, 48'h4000, 48'h100_0000, 0, 0, 2},
        '{0, BVS_FIXED32_MILLI, 0, 0, 48'd1000, 48'h1_0000, 0, 0, 5},
        '{0, BVS_SCALED_INT16, 0, 0, 48'd3, 48'h1_8000, 0, 0, 2},
        '{0, BVS_SCALED_INT16, 1, 0, 48'd5, 48'h8000, 0, 0, 3},
        '{0, BVS_SCALED_INT16, 2, 0, 48'd8, 48'h2_0000, 0, 0, 2},
        '{0, BVS_SCALED_INT32, 0, 0, 48'd100, 48'h1_0000, 0, 0, 4},
        '{0, BVS_SCALED_INT32, 8, 0, 48'd8, 48'h2_0000, 0, 0, 2},
        '{0, BVS_SCALED_INT32, 9, 0, 48'd2000, 48'h2_0000, 0, 0, 5},
        '{0, BVS_BIT_SEQUENCE_16, 0, 0, 48'h1234_a5c3, 48'ha5c3, 0, 0, 2},
        '{0, BVS_OCTET_STRING, 0, 2, 48'h1122_3344, 48'h1122_0000, 0, 0, 2},
        '{1, BVS_INT8, 0, 0, 48'hc8_0000, 48'h7f, 1, 0, 2},
        '{1, BVS_INT16, 0, 0, 48'hffff_fffe_8000, 48'hfffe, 0, 0, 2},
        '{1, BVS_UINT16, 0, 0, 48'hffff_ffff_0000, 48'h0, 1, 0, 2},
        '{0, 4'hc, 0, 0, 48'h1, 48'h0, 0, 1, 1},
        '{0, BVS_SCALED_INT32, 1, 0, 48'd1, 48'h0, 0, 1, 1},
        '{0, BVS_SCALED_INT32, 2, 0, 48'd1, 48'h0, 0, 1, 1},
        '{0, BVS_SCALED_INT16, 11, 0, 48'd1, 48'h0, 0, 1, 1},
        '{0, BVS_OCTET_STRING, 0, 5, 48'h1, 48'h0, 0, 1, 1}
    };

    always #25 mclk_in = ~mclk_in;

    bvs_scaler #(.FRAC(16), .INT_W(48)) dut_u (
        .mclk_in(mclk_in), .rst_in(rst_in), .ce_in(ce_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
        .conv_start_in(conv_start_in), .conv_dir_in(conv_dir_in), .conv_fmt_in(conv_fmt_in),
        .conv_idx_in(conv_idx_in), .conv_len_in(conv_len_in), .conv_data_in(conv_data_in),
        .conv_ready_out(conv_ready_out), .res_valid_out(res_valid_out), .res_data_out(res_data_out),
        .res_sat_out(res_sat_out), .res_err_out(res_err_out));
    bvs_fieldbus_master fm_u (
        .mclk_in(mclk_in), .ready_in(conv_ready_out), .valid_in(res_valid_out), .result_in(res_data_out),
        .sat_in(res_sat_out), .err_in(res_err_out), .start_out(conv_start_in), .dir_out(conv_dir_in),
        .fmt_out(conv_fmt_in), .idx_out(conv_idx_in), .len_out(conv_len_in), .data_out(conv_data_in));

    // One comparison
    task automatic tally(input logic ok, input string what);
        tests_run++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("CHECK FAILED at %0t: %s", $time, what);
        end
    endtask
    // Register write, one idle edge after
    task automatic reg_write(input logic [4:0] a, input logic [15:0] d);
        reg_addr_in  <= a;
        reg_wdata_in <= d;
        reg_wr_in    <= 1'b1;
        @(posedge mclk_in);
        reg_wr_in <= 1'b0;
        @(posedge mclk_in);
    endtask
    // Register read, data checked the cycle after
    task automatic rd_check(input logic [4:0] a, input logic [15:0] exp, input string what);
        reg_addr_in <= a;
        reg_rd_in   <= 1'b1;
        @(posedge mclk_in);
        reg_rd_in <= 1'b0;
        @(posedge mclk_in);
        tally(reg_rdata_out === exp, what);
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Hang guard, far above the run's length
    always @(posedge mclk_in) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            bad_count++;
            wrap_up();
        end
    end

    // Main sequence
    initial begin
        repeat (20) @(posedge mclk_in);
        rst_in <= 1'b0;
        @(posedge mclk_in);
        rd_check(IDX_Y2_SPEED, 16'h0000, "short factor reset value");
        rd_check(IDX_Y4_ACCEL_INPUT, 16'h0000, "long factor reset value");
        $display("test reset values done");
        for (int k = 0; k < 8; k++) reg_write(sa[k], sv[k]);
        for (int k = 0; k < 23; k++) begin
            fm_u.transfer(rows[k].dir, rows[k].fmt, rows[k].idx, rows[k].len, rows[k].data, got, s, e, lat);
            tally(got === rows[k].exp && s === rows[k].sat && e === rows[k].err && lat == rows[k].lat,
                  $sformatf("conversion row %0d got %h", k, got));
        end
        $display("test conversion table done");
        rd_check(IDX_STATUS, 16'h0006, "sticky error and clamp flags");
        reg_write(IDX_STATUS, 16'h0006);
        rd_check(IDX_STATUS, 16'h0000, "flags cleared by write");
        $display("test status done");
        for (int k = 0; k < 24; k++) reg_write(5'(k), 16'ha5c0 ^ 16'(k));
        for (int k = 0; k < 24; k++) rd_check(5'(k), 16'ha5c0 ^ 16'(k), "factor readback");
        rd_check(5'h1f, 16'h0000, "unmapped index reads zero");
        ce_in <= 1'b0;
        rd_check(5'h03, 16'h0000, "strobe ignored while enable low");
        ce_in <= 1'b1;
        $display("test register map done");
        rst_in <= 1'b1;
        repeat (2) @(posedge mclk_in);
        rst_in <= 1'b0;
        @(posedge mclk_in);
        rd_check(IDX_Y4_INTERPOLATION, 16'h0000, "factor after second reset");
        fm_u.transfer(1'b0, BVS_SCALED_INT32, 4'h8, 3'h0, 48'd8, got, s, e, lat);
        tally(got === 48'h8_0000 && e === 1'b0 && lat == 2, "unit factor after reset");
        $display("test second reset done");
        wrap_up();
    end
endmodule
